// ---- rtl/psl_pkg.sv ----
// shared constants and state types for the strap and status pin block
package psl_pkg;

    localparam int          NUM_PINS        = 5;
    localparam int          CNT_W           = 24;

    // pin order within the shared vector: address bit number equals index
    localparam int          PIN_RX          = 4;
    localparam int          PIN_TX          = 3;
    localparam int          PIN_LINK        = 2;
    localparam int          PIN_COLL        = 1;
    localparam int          PIN_ACT         = 0;

    localparam int          CLK_HZ          = 200_000_000;
    localparam int          COLL_STRETCH_MS = 70;
    // longest time, so rounded down to whole cycles
    localparam int          COLL_STRETCH_CYC = COLL_STRETCH_MS * (CLK_HZ / 1000);

    typedef enum logic [0:0] {
        ST_STRAP = 1'h0,
        ST_DRIVE = 1'h1
    } psl_state_e;

    typedef struct packed {
        psl_state_e          state;
        logic [NUM_PINS-1:0] strap;
        logic [NUM_PINS-1:0] led_o;
        logic                led_oe;
        logic                speed;
        logic                pair_a_tx;
        logic                addr_match;
    } psl_top_s;

    typedef struct packed {
        logic [CNT_W-1:0]    cnt;
        logic                lit;
    } psl_stretch_s;

    localparam psl_top_s TOP_RST = '{
        state:      ST_STRAP,
        strap:      5'h00,
        led_o:      5'h00,
        led_oe:     1'h0,
        speed:      1'h0,
        pair_a_tx:  1'h1,
        addr_match: 1'h0
    };

    localparam psl_stretch_s STRETCH_RST = '{cnt: 24'h000000, lit: 1'h0};

endpackage

// ---- rtl/psl_stretch_if.sv ----
// collision event in, stretched indication out
`timescale 1ns/1ps
interface psl_stretch_if;
    logic hit;
    logic lit;
    modport src (output hit, input lit);
    modport str (input hit, output lit);
endinterface

// ---- rtl/psl_stretch.sv ----
// pulse stretcher for the collision indication
`timescale 1ns/1ps
module psl_stretch #(
    parameter int STRETCH = psl_pkg::COLL_STRETCH_CYC
) (
    input  wire logic      clk,
    input  wire logic      rst,
    psl_stretch_if.str     sif
);

    psl_pkg::psl_stretch_s st_reg;
    psl_pkg::psl_stretch_s st_next;

    always_comb begin
        st_next = st_reg;
        if (rst) begin
            st_next = psl_pkg::STRETCH_RST;
        end else if (sif.hit) begin
            // reload on every collision, so a burst keeps the lamp lit
            st_next.cnt = psl_pkg::CNT_W'(STRETCH);
            st_next.lit = 1'h1;
        end else if (st_reg.cnt != '0) begin
            st_next.cnt = st_reg.cnt - psl_pkg::CNT_W'(1);
            st_next.lit = 1'h1;
        end else begin
            st_next.lit = 1'h0;
        end
    end

    always_ff @(posedge clk) begin
        st_reg <= st_next;
    end

    assign sif.lit = st_reg.lit;

    coll_seen_a: assert property (
        @(posedge clk) disable iff (rst) sif.hit |=> sif.lit)
        else $error("collision not indicated on the next cycle");

    coll_hold_a: assert property (
        @(posedge clk) disable iff (rst)
        (!sif.hit && st_reg.cnt != '0) |=> (sif.lit && st_reg.cnt == $past(st_reg.cnt) - 1))
        else $error("stretched collision dropped or count not falling");

    coll_quiet_a: assert property (
        @(posedge clk) disable iff (rst)
        (!sif.hit && st_reg.cnt == '0) |=> !sif.lit)
        else $error("collision shown with no collision pending");

endmodule

// ---- rtl/psl_pin_mux.sv ----
// shared address strap / status lamp pins with speed, crossover and address match
// Function
// - in hardware reset pins are inputs, latched at release
// - after sampling, pins become status outputs
// - software reset keeps straps and output direction
// - asserted output is inverse of latched strap
// - pins 4..0: receive, transmit, link, collision, activity
// - latched low gives address zero, high one
// - collision lamp stretched about seventy milliseconds
// - collision lamp follows detected collisions
// - activity lamp follows line activity
// - speed output high at 100 Mb/s
// - crossover enable pin high allows automatic selection
// - system reset input is active low
// - link lamp follows valid link
// - transmit lamp follows transmit activity
// - crossover enable low forces pair A transmit
`timescale 1ns/1ps
module psl_pin_mux #(
    parameter int COLL_STRETCH_CYCLES = psl_pkg::COLL_STRETCH_CYC
) (
    input  wire logic       CORE_CLK,
    input  wire logic       RST,
    input  wire logic       SYSTEM_RESET_N,
    input  wire logic       SW_RESET,
    input  wire logic       ADDR4_RX_LED_PIN_I,
    output logic            ADDR4_RX_LED_PIN_O,
    output logic            ADDR4_RX_LED_PIN_OE,
    input  wire logic       ADDR3_TX_LED_PIN_I,
    output logic            ADDR3_TX_LED_PIN_O,
    output logic            ADDR3_TX_LED_PIN_OE,
    input  wire logic       ADDR2_LINK_LED_PIN_I,
    output logic            ADDR2_LINK_LED_PIN_O,
    output logic            ADDR2_LINK_LED_PIN_OE,
    input  wire logic       ADDR1_COLLISION_LED_PIN_I,
    output logic            ADDR1_COLLISION_LED_PIN_O,
    output logic            ADDR1_COLLISION_LED_PIN_OE,
    input  wire logic       ADDR0_ACTIVITY_LED_PIN_I,
    output logic            ADDR0_ACTIVITY_LED_PIN_O,
    output logic            ADDR0_ACTIVITY_LED_PIN_OE,
    input  wire logic       RX_ACTIVE,
    input  wire logic       TX_ACTIVE,
    input  wire logic       LINK_VALID,
    input  wire logic       COLLISION_DET,
    input  wire logic       LINE_ACTIVE,
    input  wire logic       SPEED_100,
    input  wire logic       AUTO_CROSSOVER_ENABLE_PIN,
    input  wire logic       AUTO_CROSS_SEL,
    input  wire logic [4:0] MGMT_FRAME_ADDR,
    output logic [4:0]      PHY_ADDRESS_BITS,
    output logic            ADDR_MATCH,
    output logic            SPEED_IND,
    output logic            PAIR_A_TX
);

    psl_pkg::psl_top_s      st_reg;
    psl_pkg::psl_top_s      st_next;
    logic                   hw_rst;
    logic                   stretch_rst;
    logic [4:0]             pin_in;
    logic [4:0]             ind;
    logic                   cross_sel;

    psl_stretch_if          coll_if ();

    // power-on and pin reset both count as hardware reset
    assign hw_rst      = RST | ~SYSTEM_RESET_N;
    assign stretch_rst = hw_rst | SW_RESET;

    assign pin_in = {ADDR4_RX_LED_PIN_I, ADDR3_TX_LED_PIN_I, ADDR2_LINK_LED_PIN_I,
                     ADDR1_COLLISION_LED_PIN_I, ADDR0_ACTIVITY_LED_PIN_I};

    assign coll_if.hit = COLLISION_DET;

    psl_stretch #(
        .STRETCH (COLL_STRETCH_CYCLES)
    ) u_coll_stretch (
        .clk     (CORE_CLK),
        .rst     (stretch_rst),
        .sif     (coll_if)
    );

    // indication vector in address-bit order
    always_comb begin
        ind                     = 5'h00;
        ind[psl_pkg::PIN_RX]    = RX_ACTIVE;
        ind[psl_pkg::PIN_TX]    = TX_ACTIVE;
        ind[psl_pkg::PIN_LINK]  = LINK_VALID;
        ind[psl_pkg::PIN_COLL]  = coll_if.lit;
        ind[psl_pkg::PIN_ACT]   = LINE_ACTIVE;
    end

    // pin low forces straight pairing whatever the detector says
    assign cross_sel = AUTO_CROSSOVER_ENABLE_PIN & AUTO_CROSS_SEL;

    always_comb begin
        st_next = st_reg;
        if (hw_rst) begin
            // pins released so the strap resistors set the level
            st_next = psl_pkg::TOP_RST;
        end else begin
            case (st_reg.state)
                psl_pkg::ST_STRAP: begin
                    // first cycle out of reset: take the strap levels
                    st_next.strap  = pin_in;
                    st_next.led_o  = 5'h00;
                    st_next.led_oe = 1'h0;
                    st_next.state  = psl_pkg::ST_DRIVE;
                end
                psl_pkg::ST_DRIVE: begin
                    // strap and direction untouched by software reset
                    st_next.led_oe = 1'h1;
                    if (SW_RESET) begin
                        st_next.led_o = st_reg.strap;
                    end else begin
                        st_next.led_o = st_reg.strap ^ ind;
                    end
                end
                default: begin
                    st_next = psl_pkg::TOP_RST;
                end
            endcase
            st_next.speed      = SPEED_100;
            st_next.pair_a_tx  = ~cross_sel;
            st_next.addr_match = (st_reg.state == psl_pkg::ST_DRIVE) &&
                                 (MGMT_FRAME_ADDR == st_reg.strap);
        end
    end

    always_ff @(posedge CORE_CLK) begin
        st_reg <= st_next;
    end

    assign ADDR4_RX_LED_PIN_O         = st_reg.led_o[psl_pkg::PIN_RX];
    assign ADDR3_TX_LED_PIN_O         = st_reg.led_o[psl_pkg::PIN_TX];
    assign ADDR2_LINK_LED_PIN_O       = st_reg.led_o[psl_pkg::PIN_LINK];
    assign ADDR1_COLLISION_LED_PIN_O  = st_reg.led_o[psl_pkg::PIN_COLL];
    assign ADDR0_ACTIVITY_LED_PIN_O   = st_reg.led_o[psl_pkg::PIN_ACT];
    assign ADDR4_RX_LED_PIN_OE        = st_reg.led_oe;
    assign ADDR3_TX_LED_PIN_OE        = st_reg.led_oe;
    assign ADDR2_LINK_LED_PIN_OE      = st_reg.led_oe;
    assign ADDR1_COLLISION_LED_PIN_OE = st_reg.led_oe;
    assign ADDR0_ACTIVITY_LED_PIN_OE  = st_reg.led_oe;
    assign PHY_ADDRESS_BITS           = st_reg.strap;
    assign ADDR_MATCH                 = st_reg.addr_match;
    assign SPEED_IND                  = st_reg.speed;
    assign PAIR_A_TX                  = st_reg.pair_a_tx;

    pins_in_reset_a: assert property (
        @(posedge CORE_CLK) disable iff (RST) !SYSTEM_RESET_N |=> !st_reg.led_oe)
        else $error("shared pins driven during hardware reset");

    strap_capture_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (!hw_rst && st_reg.state == psl_pkg::ST_STRAP) |=>
            (PHY_ADDRESS_BITS == $past(pin_in) && !st_reg.led_oe))
        else $error("strap levels not latched at reset release");

    drive_after_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (!hw_rst && st_reg.state == psl_pkg::ST_STRAP) ##1 !hw_rst |=> st_reg.led_oe)
        else $error("shared pins not driven after sampling");

    sw_reset_keep_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (SW_RESET && SYSTEM_RESET_N && st_reg.led_oe) |=>
            (st_reg.led_oe && $stable(PHY_ADDRESS_BITS)))
        else $error("software reset disturbed strap or direction");

    led_polarity_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (!hw_rst && !SW_RESET && st_reg.state == psl_pkg::ST_DRIVE) |=>
            (st_reg.led_o == (st_reg.strap ^ $past(ind))))
        else $error("lamp level not inverse of strap when asserted");

    addr_match_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (!hw_rst && st_reg.state == psl_pkg::ST_DRIVE) |=>
            (ADDR_MATCH == ($past(MGMT_FRAME_ADDR) == PHY_ADDRESS_BITS)))
        else $error("address match wrong");

    speed_out_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !hw_rst |=> (SPEED_IND == $past(SPEED_100)))
        else $error("speed indication wrong");

    straight_pair_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !AUTO_CROSSOVER_ENABLE_PIN |=> PAIR_A_TX)
        else $error("crossover taken with enable pin low");

    auto_cross_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (!hw_rst && AUTO_CROSSOVER_ENABLE_PIN && AUTO_CROSS_SEL) |=> !PAIR_A_TX)
        else $error("automatic crossover not applied");

    strap_held_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (!hw_rst && st_reg.state == psl_pkg::ST_DRIVE) |=> $stable(PHY_ADDRESS_BITS))
        else $error("latched address moved outside hardware reset");

    no_resample_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (!hw_rst && st_reg.state == psl_pkg::ST_DRIVE) |=>
            (st_reg.state == psl_pkg::ST_DRIVE && st_reg.led_oe))
        else $error("strap sampling repeated without hardware reset");

    sw_reset_dark_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (SW_RESET && !hw_rst && st_reg.state == psl_pkg::ST_DRIVE) |=>
            (st_reg.led_o == st_reg.strap))
        else $error("status shown during software reset");

    reset_pin_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        !SYSTEM_RESET_N |=>
            (st_reg.state == psl_pkg::ST_STRAP && PHY_ADDRESS_BITS == 5'h00))
        else $error("low reset pin did not hold the block in reset");

    rx_lamp_pin_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (!hw_rst && !SW_RESET && st_reg.state == psl_pkg::ST_DRIVE) |=>
            (ADDR4_RX_LED_PIN_O == (st_reg.strap[psl_pkg::PIN_RX] ^ $past(RX_ACTIVE))))
        else $error("receive status not on address bit four pin");

    coll_lamp_pin_a: assert property (
        @(posedge CORE_CLK) disable iff (RST)
        (!hw_rst && !SW_RESET && st_reg.state == psl_pkg::ST_DRIVE && coll_if.lit) |=>
            (ADDR1_COLLISION_LED_PIN_O != st_reg.strap[psl_pkg::PIN_COLL]))
        else $error("stretched collision not shown on its pin");

endmodule

// ---- test/psl_led_model.sv ----
// strap resistor and status lamp hanging on each shared pin
`timescale 1ns/1ps
module psl_led_model (
    input  wire logic [4:0] strap,
    input  wire logic [4:0] led_o,
    input  wire logic [4:0] led_oe,
    output logic [4:0]      pin_lvl,
    output logic [4:0]      lamp
);
    // an undriven pin settles to its resistor, never floats
    assign pin_lvl = (led_oe & led_o) | (~led_oe & strap);
    // lamp in series with the resistor: lit only when the pin opposes it
    assign lamp = led_oe & (led_o ^ strap);
endmodule

// ---- test/tb.sv ----
// self-checking bench for the shared strap and status pin block
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; \
    $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module tb;
    localparam int N = 8;
    logic       CORE_CLK = 1'h0;
    logic       RST = 1'h1;
    logic       rst_n = 1'h1;
    logic       sw_rst = 1'h0;
    logic [4:0] st = 5'h00;
    logic       spd = 1'h0;
    logic       aen = 1'h1;
    logic       sel = 1'h0;
    logic [4:0] mga = 5'h00;
    logic [4:0] strap = 5'h15;
    wire  [4:0] pin_lvl;
    wire  [4:0] lamp;
    wire  [4:0] pin_o;
    wire  [4:0] pin_oe;
    logic [4:0] addr;
    logic       match;
    logic       spd_ind;
    logic       pair_a;
    int         fail_count = 0;
    int         n_tests = 0;
    int         cycles = 0;
    // status[8:4] speed[3] crossover pin[2] detector[1] address hit[0]
    logic [8:0] rows [6] = '{9'h10f, 9'h084, 9'h04b, 9'h010, 9'h1dd, 9'h006};

    psl_pin_mux #(.COLL_STRETCH_CYCLES(N)) i_dut (
        .CORE_CLK(CORE_CLK), .RST(RST), .SYSTEM_RESET_N(rst_n), .SW_RESET(sw_rst),
        .ADDR4_RX_LED_PIN_I(pin_lvl[4]), .ADDR4_RX_LED_PIN_O(pin_o[4]),
        .ADDR4_RX_LED_PIN_OE(pin_oe[4]), .ADDR3_TX_LED_PIN_I(pin_lvl[3]),
        .ADDR3_TX_LED_PIN_O(pin_o[3]), .ADDR3_TX_LED_PIN_OE(pin_oe[3]),
        .ADDR2_LINK_LED_PIN_I(pin_lvl[2]), .ADDR2_LINK_LED_PIN_O(pin_o[2]),
        .ADDR2_LINK_LED_PIN_OE(pin_oe[2]), .ADDR1_COLLISION_LED_PIN_I(pin_lvl[1]),
        .ADDR1_COLLISION_LED_PIN_O(pin_o[1]), .ADDR1_COLLISION_LED_PIN_OE(pin_oe[1]),
        .ADDR0_ACTIVITY_LED_PIN_I(pin_lvl[0]), .ADDR0_ACTIVITY_LED_PIN_O(pin_o[0]),
        .ADDR0_ACTIVITY_LED_PIN_OE(pin_oe[0]),
        .RX_ACTIVE(st[4]), .TX_ACTIVE(st[3]), .LINK_VALID(st[2]),
        .COLLISION_DET(st[1]), .LINE_ACTIVE(st[0]), .SPEED_100(spd),
        .AUTO_CROSSOVER_ENABLE_PIN(aen), .AUTO_CROSS_SEL(sel), .MGMT_FRAME_ADDR(mga),
        .PHY_ADDRESS_BITS(addr), .ADDR_MATCH(match), .SPEED_IND(spd_ind),
        .PAIR_A_TX(pair_a)
    );

    psl_led_model i_leds (
        .strap(strap), .led_o(pin_o), .led_oe(pin_oe), .pin_lvl(pin_lvl), .lamp(lamp)
    );

    initial begin
        forever #2.5 CORE_CLK = ~CORE_CLK;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge CORE_CLK);
    endtask

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // a hang counts as a mismatch
    always @(posedge CORE_CLK) begin
        cycles++;
        if (cycles == 2000) begin
            fail_count++;
            finish_test();
        end
    end

    initial begin
        cyc(5);
        #1 `CHK(pin_oe, 5'h00)
        `CHK(pin_o, 5'h00)
        cyc(5);
        RST <= 1'h0;
        cyc(3);
        #1 `CHK(addr, strap)
        `CHK(pin_oe, 5'h1f)
        `CHK(lamp, 5'h00)
        foreach (rows[i]) begin
            cyc(1);
            st <= rows[i][8:4];
            spd <= rows[i][3];
            aen <= rows[i][2];
            sel <= rows[i][1];
            mga <= rows[i][0] ? strap : strap ^ 5'h04;
            cyc(2);
            #1 `CHK(lamp, rows[i][8:4])
            `CHK(pin_o, strap ^ rows[i][8:4])
            `CHK(spd_ind, rows[i][3])
            `CHK(pair_a, ~(rows[i][2] & rows[i][1]))
            `CHK(match, rows[i][0])
        end
        // one-cycle collision must be stretched to N+1 cycles, then drop
        cyc(1);
        st <= 5'h02;
        cyc(1);
        st <= 5'h00;
        cyc(3);
        #1 `CHK(lamp, 5'h02)
        cyc(5);
        #1 `CHK(lamp, 5'h02)
        cyc(6);
        #1 `CHK(lamp, 5'h00)
        // software reset: outputs kept, lamps dark, address kept
        cyc(1);
        st <= 5'h10;
        sw_rst <= 1'h1;
        cyc(3);
        #1 `CHK(pin_oe, 5'h1f)
        `CHK(pin_o, strap)
        `CHK(addr, 5'h15)
        cyc(1);
        sw_rst <= 1'h0;
        cyc(2);
        #1 `CHK(lamp, 5'h10)
        // hardware reset pin low resamples a new strap pattern
        cyc(1);
        st <= 5'h00;
        rst_n <= 1'h0;
        strap <= 5'h0a;
        cyc(4);
        #1 `CHK(pin_oe, 5'h00)
        cyc(1);
        rst_n <= 1'h1;
        cyc(3);
        #1 `CHK(addr, 5'h0a)
        `CHK(pin_o, 5'h0a)
        cyc(4);
        #1 `CHK(addr, 5'h0a)
        finish_test();
    end
endmodule
